// ### rtl/sfc_spi_frame_check.sv
`include "sfc_defines.svh"
module sfc_spi_frame_check (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic chip_select_n_in,
    input wire logic serial_clock_in,
    input wire logic serial_in_in,
    input wire logic reset_output_pin_in,
    input wire sfc_pkg::sfc_mode_t mode_in,
    input wire logic [5:0] mode_ctrl_shadow_in,
    input wire logic [7:0] wake_source_enable_control_in,
    input wire logic [7:0] bus_ctrl_enable_in,
    input wire logic wake_input_measure_enable_in,
    input wire logic [7:0] wake_status_first_in,
    input wire logic [7:0] wake_status_second_in,
    input wire logic timer_off_in,
    input wire logic [14:0] rsp_word_in,
    output logic serial_out_out,
    output logic serial_out_oe_out,
    output logic cmd_valid_out,
    output logic cmd_write_out,
    output logic [6:0] cmd_addr_out,
    output logic [7:0] cmd_data_out,
    output logic mode_req_valid_out,
    output logic [1:0] mode_req_out,
    output logic restart_req_out,
    output logic cmd_fail_out,
    output logic wake_int_out,
    output logic frame_err_out
);
    import sfc_pkg::*;

    logic cs_s, sck_s, sdi_s, ro_s;
    logic cs_d_ff, sck_d_ff;
    logic cs_fall, cs_rise, sck_rise, sck_fall;
    sfc_fstate_t state_ff;
    logic [15:0] rx_ff;
    logic [15:0] tx_ff;
    logic [4:0] cnt_ff;
    logic bad_ff, err_ff, fail_ff;
    logic sdo_ff, oe_ff;
    logic frame_end, frame_bad, take;
    logic dead_timer, dead_timer_ff;
    logic cmd_valid_ff, cmd_write_ff, mreq_valid_ff, restart_ff, wake_int_ff;
    logic [6:0] cmd_addr_ff;
    logic [7:0] cmd_data_ff;
    logic [1:0] mreq_ff;
    sfc_frame_if fif ();

    // Pins from the host cross into our clock; reset pin too, for safety
    sfc_sync #(.W(4)) u_sync (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .async_in({chip_select_n_in, serial_clock_in, serial_in_in, reset_output_pin_in}),
        .rst_val_in(4'h9), // Idle: select high, clock low, data low, reset output high
        .sync_out({cs_s, sck_s, sdi_s, ro_s})
    );

    // Delayed copies for edge finding
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cs_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
        end else begin
            cs_d_ff <= cs_s;
            sck_d_ff <= sck_s;
        end
    end

    assign cs_fall = cs_d_ff && !cs_s;
    assign cs_rise = !cs_d_ff && cs_s;
    assign sck_rise = !sck_d_ff && sck_s;
    assign sck_fall = sck_d_ff && !sck_s;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= fs_idle;
        end else begin
            case (state_ff)
                fs_idle: begin
                    if (cs_fall) begin
                        state_ff <= fs_active;
                    end
                end
                fs_active: begin
                    if (cs_rise) begin
                        state_ff <= fs_idle;
                    end
                end
                default: begin
                    state_ff <= fs_idle;
                end
            endcase
        end
    end

    // sample on falling clock, LSB first
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_ff <= `SFC_ZERO_WORD;
        end else if (state_ff == fs_active && sck_fall) begin
            rx_ff <= {sdi_s, rx_ff[15:1]};
        end
    end

    // clock pulse counter, saturating so long frames stay wrong
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_ff <= `SFC_CNT_ZERO;
        end else if (state_ff == fs_idle && cs_fall) begin
            cnt_ff <= `SFC_CNT_ZERO;
        end else if (state_ff == fs_active && sck_fall && cnt_ff != `SFC_CNT_MAX) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end

    // response loaded at frame start, error bit leads it
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_ff <= `SFC_ONES_WORD;
        end else if (state_ff == fs_idle && cs_fall) begin
            tx_ff <= {rsp_word_in, err_ff};
        end else if (state_ff == fs_active && sck_rise) begin
            tx_ff <= {1'b0, tx_ff[15:1]};
        end
    end

    // clock high at opening edge, or reset low during frame
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bad_ff <= 1'b0;
        end else if (state_ff == fs_idle && cs_fall) begin
            bad_ff <= sck_s || !ro_s;
        end else if (state_ff == fs_active && !ro_s) begin
            bad_ff <= 1'b1;
        end
    end

    assign frame_end = (state_ff == fs_active) && cs_rise;
    // count neither 0 nor 16, or clock high at the closing edge
    assign frame_bad = bad_ff || sck_s || !ro_s ||
        (cnt_ff != `SFC_CNT_ZERO && cnt_ff != `SFC_CNT_FULL);
    assign take = frame_end && !frame_bad && cnt_ff == `SFC_CNT_FULL &&
        mode_in != sfc_mode_restart;

    // error shown in the next frame, then cleared; a new error wins
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            err_ff <= 1'b0;
        end else if (frame_end) begin
            err_ff <= frame_bad;
        end
    end

    // output high in reset, line released outside frames even then
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sdo_ff <= 1'b1;
            oe_ff <= 1'b0;
        end else begin
            sdo_ff <= !ro_s || tx_ff[0];
            oe_ff <= (state_ff == fs_active);
        end
    end

    // Word and context handed to the judge
    assign fif.word = rx_ff;
    assign fif.mode = mode_in;
    assign fif.mode_other = mode_ctrl_shadow_in;
    assign fif.wake_en = wake_source_enable_control_in;
    assign fif.bus_en = bus_ctrl_enable_in;
    assign fif.meas_en = wake_input_measure_enable_in;

    sfc_cmd_check u_check (
        .fif(fif)
    );

    // sticky fail flag; a fresh failure beats a clear in the same frame
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fail_ff <= 1'b0;
        end else if (take && fif.fail) begin
            fail_ff <= 1'b1;
        end else if (take && fif.exec && fif.fail_clear) begin
            fail_ff <= 1'b0;
        end
    end

    // stopped timer as sole wake source while asleep
    assign dead_timer = (mode_in == sfc_mode_sleep) && timer_off_in &&
        wake_source_enable_control_in == `SFC_WAKE_TIMER_MASK && bus_ctrl_enable_in == 8'h00;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dead_timer_ff <= 1'b0;
        end else begin
            dead_timer_ff <= dead_timer;
        end
    end

    // accepted commands as one-cycle pulses with held fields
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_valid_ff <= 1'b0;
            cmd_write_ff <= 1'b0;
            cmd_addr_ff <= 7'h00;
            cmd_data_ff <= 8'h00;
        end else begin
            cmd_valid_ff <= take && fif.exec;
            if (take && fif.exec) begin
                cmd_write_ff <= rx_ff[`SFC_RW_BIT];
                cmd_addr_ff <= rx_ff[`SFC_ADDR_MSB:0];
                cmd_data_ff <= rx_ff[`SFC_DATA_MSB:`SFC_DATA_LSB];
            end
        end
    end

    // mode requests, restart and wake interrupt
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mreq_valid_ff <= 1'b0;
            mreq_ff <= `SFC_MODE_NORMAL;
            restart_ff <= 1'b0;
            wake_int_ff <= 1'b0;
        end else begin
            mreq_valid_ff <= take && fif.mchg;
            if (take && fif.mchg) begin
                mreq_ff <= fif.mcode;
            end
            restart_ff <= (take && fif.restart) || (dead_timer && !dead_timer_ff);
            wake_int_ff <= take && fif.mchg && fif.mcode == `SFC_MODE_STOP &&
                (wake_status_first_in != 8'h00 || wake_status_second_in != 8'h00);
        end
    end

    assign serial_out_out = sdo_ff;
    assign serial_out_oe_out = oe_ff;
    assign cmd_valid_out = cmd_valid_ff;
    assign cmd_write_out = cmd_write_ff;
    assign cmd_addr_out = cmd_addr_ff;
    assign cmd_data_out = cmd_data_ff;
    assign mode_req_valid_out = mreq_valid_ff;
    assign mode_req_out = mreq_ff;
    assign restart_req_out = restart_ff;
    assign cmd_fail_out = fail_ff;
    assign wake_int_out = wake_int_ff;
    assign frame_err_out = err_ff;

    // Checks on the frame path
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    sequence s_open_clock_high;
        state_ff == fs_idle && cs_fall && sck_s;
    endsequence

    sequence s_close_miscounted;
        frame_end && cnt_ff != `SFC_CNT_ZERO && cnt_ff != `SFC_CNT_FULL;
    endsequence

    sequence s_stuck_taken;
        take && (rx_ff == `SFC_ZERO_WORD || rx_ff == `SFC_ONES_WORD);
    endsequence

    property p_release_out;
        frame_end && ro_s |-> ##2 !serial_out_oe_out;
    endproperty
    a_release_out: assert property (p_release_out) else $error("output not released");

    property p_sample_fall;
        state_ff == fs_active && sck_fall |=> rx_ff[15] == $past(sdi_s);
    endproperty
    a_sample_fall: assert property (p_sample_fall) else $error("input bit not sampled");

    property p_shift_rise;
        state_ff == fs_active && sck_rise && !cs_rise && ro_s |=>
        ##1 serial_out_out == $past(tx_ff[1], 2) || !$past(ro_s);
    endproperty
    a_shift_rise: assert property (p_shift_rise) else $error("output bit not shifted");

    property p_count_err;
        s_close_miscounted |=> frame_err_out && !cmd_valid_out;
    endproperty
    a_count_err: assert property (p_count_err) else $error("bad count not flagged");

    property p_clock_high_err;
        s_open_clock_high |=> (bad_ff throughout (state_ff == fs_active)[*2]) or !cs_s;
    endproperty
    a_clock_high_err: assert property (p_clock_high_err) else $error("clock high not caught");

    property p_reset_high;
        !ro_s && state_ff == fs_active |=> serial_out_out && serial_out_oe_out;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("output not high in reset");

    property p_fail_sticky;
        cmd_fail_out && !(take && fif.exec && fif.fail_clear) |=> cmd_fail_out;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag dropped");

    property p_stuck_fail;
        s_stuck_taken |=> cmd_fail_out && !cmd_valid_out;
    endproperty
    a_stuck_fail: assert property (p_stuck_fail) else $error("stuck word accepted");

    property p_restart_deaf;
        frame_end && mode_in == sfc_mode_restart |=> !cmd_valid_out && !mode_req_valid_out;
    endproperty
    a_restart_deaf: assert property (p_restart_deaf) else $error("frame used in restart");

    property p_init_normal;
        take && mode_in == sfc_mode_init && rx_ff[`SFC_ADDR_MSB:0] == `SFC_ADDR_MODE_CTRL &&
        rx_ff[`SFC_RW_BIT] && rx_ff[15:14] == `SFC_MODE_STOP && !fif.fail_clear
        |=> mode_req_valid_out && mode_req_out == `SFC_MODE_NORMAL && cmd_fail_out;
    endproperty
    a_init_normal: assert property (p_init_normal) else $error("init stop not redirected");

    property p_wd_parity;
        take && rx_ff[`SFC_ADDR_MSB:0] == `SFC_ADDR_WATCHDOG_CONTROL && rx_ff[`SFC_RW_BIT] &&
        ^rx_ff[15:8] && rx_ff != `SFC_ONES_WORD |=> cmd_fail_out && !cmd_valid_out;
    endproperty
    a_wd_parity: assert property (p_wd_parity) else $error("odd parity accepted");
endmodule // sfc_spi_frame_check

// ### rtl/sfc_defines.svh
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
// Frame shape
`define SFC_WORD_W 16
`define SFC_CNT_W 5
`define SFC_CNT_FULL 5'h10
`define SFC_CNT_ZERO 5'h00
`define SFC_CNT_MAX 5'h1F
`define SFC_RSP_W 15
`define SFC_ZERO_WORD 16'h0000
`define SFC_ONES_WORD 16'hFFFF
// Word fields
`define SFC_ADDR_MSB 6
`define SFC_RW_BIT 7
`define SFC_DATA_LSB 8
`define SFC_DATA_MSB 15
// Address ranges and registers
`define SFC_ADDR_MODE_CTRL 7'h01
`define SFC_ADDR_WATCHDOG_CONTROL 7'h03
`define SFC_ADDR_TIMER_CTRL 7'h0C
`define SFC_ADDR_DEV_STAT 7'h43
`define SFC_CTRL_LAST 7'h1E
`define SFC_STAT_FIRST 7'h40
`define SFC_STAT_LAST 7'h7E
// Data byte fields
`define SFC_FAIL_CLR_BIT 2
`define SFC_MODE_MSB 7
`define SFC_MODE_LSB 6
`define SFC_OTHER_MSB 5
`define SFC_PER_MSB 3
`define SFC_PER_LSB 0
`define SFC_ON_MSB 6
`define SFC_ON_LSB 4
// Requested mode codes
`define SFC_MODE_NORMAL 2'h0
`define SFC_MODE_SLEEP 2'h1
`define SFC_MODE_STOP 2'h2
`define SFC_MODE_SOFT_RESET 2'h3
// Wake enable bits
`define SFC_WAKE_INPUT_ONE_ENABLE_BIT 0
`define SFC_WAKE_INPUT_TWO_ENABLE_BIT 1
`define SFC_WAKE_TIMER_BIT 2
`define SFC_WAKE_PAIR_MASK 8'h03
`define SFC_WAKE_TIMER_MASK 8'h04
`endif

// ### rtl/sfc_pkg.sv
package sfc_pkg;
    // Operating mode reported by the mode machine
    typedef enum logic [2:0] {
        sfc_mode_init,
        sfc_mode_normal,
        sfc_mode_stop,
        sfc_mode_sleep,
        sfc_mode_restart
    } sfc_mode_t;
    // Frame tracker states
    typedef enum logic {
        fs_idle,
        fs_active
    } sfc_fstate_t;
endpackage

// ### rtl/sfc_frame_if.sv
interface sfc_frame_if;
    import sfc_pkg::*;
    logic [15:0] word;
    sfc_mode_t mode;
    logic [5:0] mode_other;
    logic [7:0] wake_en;
    logic [7:0] bus_en;
    logic meas_en;
    logic fail;
    logic exec;
    logic mchg;
    logic [1:0] mcode;
    logic restart;
    logic fail_clear;
    modport frame (output word, mode, mode_other, wake_en, bus_en, meas_en,
                   input fail, exec, mchg, mcode, restart, fail_clear);
    modport judge (input word, mode, mode_other, wake_en, bus_en, meas_en,
                   output fail, exec, mchg, mcode, restart, fail_clear);
endinterface

// ### rtl/sfc_sync.sv
module sfc_sync #(
    parameter int W = 4
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [W-1:0] async_in,
    input wire logic [W-1:0] rst_val_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] stable_ff;
    logic [1:0] primed_ff;
    // Two stages per bit; the first stage feeds only the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clock_in or negedge rstn_in) begin
            if (!rstn_in) begin
                meta_ff[i] <= 1'b1;
                stable_ff[i] <= 1'b1;
            end else begin
                meta_ff[i] <= async_in[i];
                stable_ff[i] <= meta_ff[i];
            end
        end
    end
    // Idle levels stand in until both stages hold real pin values, so no false edge after reset
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            primed_ff <= 2'h0;
        end else begin
            primed_ff <= {primed_ff[0], 1'b1};
        end
    end
    assign sync_out = primed_ff[1] ? stable_ff : rst_val_in;
endmodule // sfc_sync

// ### rtl/sfc_cmd_check.sv
`include "sfc_defines.svh"
module sfc_cmd_check (
    sfc_frame_if.judge fif
);
    import sfc_pkg::*;
    logic [6:0] addr;
    logic [7:0] data;
    logic wr, is_ctrl, is_stat, stuck, no_wake, pair_only;
    logic [1:0] req;
    assign addr = fif.word[`SFC_ADDR_MSB:0];
    assign data = fif.word[`SFC_DATA_MSB:`SFC_DATA_LSB];
    assign wr = fif.word[`SFC_RW_BIT];
    assign req = data[`SFC_MODE_MSB:`SFC_MODE_LSB];
    assign is_ctrl = (addr <= `SFC_CTRL_LAST);
    assign is_stat = (addr >= `SFC_STAT_FIRST) && (addr <= `SFC_STAT_LAST);
    assign stuck = (fif.word == `SFC_ZERO_WORD) || (fif.word == `SFC_ONES_WORD);
    assign no_wake = (fif.wake_en == 8'h00) && (fif.bus_en == 8'h00);
    assign pair_only = fif.meas_en && (fif.bus_en == 8'h00) &&
        ((fif.wake_en & ~`SFC_WAKE_PAIR_MASK) == 8'h00) &&
        ((fif.wake_en & `SFC_WAKE_PAIR_MASK) != 8'h00);
    assign fif.fail_clear = wr && (addr == `SFC_ADDR_DEV_STAT) && data[`SFC_FAIL_CLR_BIT];
    always_comb begin
        fif.fail = 1'b0;
        fif.exec = 1'b0;
        fif.mchg = 1'b0;
        fif.mcode = req;
        fif.restart = 1'b0;
        if (stuck) begin
            fif.fail = 1'b1;
        end else if (!(is_ctrl || is_stat)) begin
            fif.exec = 1'b0;
        end else if (!wr || is_stat) begin
            fif.exec = 1'b1;
        end else if (addr == `SFC_ADDR_WATCHDOG_CONTROL) begin
            fif.fail = ^data;
            fif.exec = ~^data;
        end else if (addr == `SFC_ADDR_MODE_CTRL) begin
            case (fif.mode)
                sfc_mode_init: begin
                    fif.mchg = 1'b1;
                    fif.exec = 1'b1;
                    if (req == `SFC_MODE_STOP || req == `SFC_MODE_SLEEP) begin
                        fif.fail = 1'b1;
                        fif.exec = 1'b0;
                        fif.mcode = `SFC_MODE_NORMAL;
                    end
                end
                sfc_mode_stop: begin
                    if (req == `SFC_MODE_SLEEP) begin
                        fif.fail = 1'b1;
                        fif.restart = 1'b1;
                    end else if (req == `SFC_MODE_STOP) begin
                        fif.fail = (data[`SFC_OTHER_MSB:0] != fif.mode_other);
                    end else begin
                        fif.mchg = 1'b1;
                        fif.fail = (data[`SFC_OTHER_MSB:0] != fif.mode_other);
                    end
                end
                default: begin
                    fif.exec = 1'b1;
                    if (req == `SFC_MODE_SLEEP && (no_wake || pair_only)) begin
                        fif.fail = 1'b1;
                        fif.restart = 1'b1;
                    end else begin
                        fif.mchg = 1'b1;
                    end
                end
            endcase
        end else if (fif.mode == sfc_mode_stop) begin
            fif.fail = 1'b1;
        end else if (addr == `SFC_ADDR_TIMER_CTRL &&
                     {1'b0, data[`SFC_ON_MSB:`SFC_ON_LSB]} >= data[`SFC_PER_MSB:`SFC_PER_LSB]) begin
            fif.fail = 1'b1;
        end else begin
            fif.exec = 1'b1;
        end
    end
endmodule // sfc_cmd_check

// ### bench/sfc_host_model.sv
module sfc_host_model (
    input wire logic clock_in,
    input wire logic sdo_in,
    input wire logic oe_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_ff = 1'b0;
    logic line;

    // Released line must not hold the old value
    always @(posedge clock_in) begin
        if (oe_in) last_ff <= sdo_in;
    end
    assign line = oe_in ? sdo_in : ~last_ff;

    // Idle bus: deselected, clock low
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end

    // clock low at select edges unless hi
    task automatic frame(input logic [15:0] w, input int n, input bit hi,
                         output logic [15:0] r);
        r = 16'hFFFF;
        sck_out = hi;
        repeat (4) @(negedge clock_in);
        cs_n_out = 1'b0;
        repeat (8) @(negedge clock_in);
        r[0] = line;
        for (int i = 0; i < n; i++) begin
            r[i] = line; // Sampled just before the rise
            sdi_out = w[i];
            sck_out = 1'b1;
            repeat (4) @(negedge clock_in);
            sck_out = 1'b0;
            repeat (4) @(negedge clock_in);
        end
        sck_out = hi;
        repeat (4) @(negedge clock_in);
        cs_n_out = 1'b1;
        repeat (4) @(negedge clock_in);
        sck_out = 1'b0;
        sdi_out = ~sdi_out;
        repeat (8) @(negedge clock_in);
    endtask
endmodule // sfc_host_model

// ### bench/test_sbc_spi_slave_frame_check.sv
module test_sbc_spi_slave_frame_check;
    timeunit 1ns;
    timeprecision 1ns;
    import sfc_pkg::*;
    typedef struct packed {
        sfc_mode_t m;
        logic [8:0] env;
        logic [7:0] st;
        logic [15:0] w;
        logic [5:0] e;
    } sfc_case_t;
    localparam logic [14:0] rsp_val = 15'h2A5B;
    logic clk = 1'b0, rstn = 1'b0, ro = 1'b1, meas = 1'b0, toff = 1'b0;
    sfc_mode_t mode = sfc_mode_normal;
    logic [7:0] wen = 8'h00, ws = 8'h00, cd;
    logic [7:0] ben = 8'h00;
    logic [5:0] shd = 6'h00;
    logic cs_n, sck, serial_in, serial_out, oe, cv, cw, mrv, rr, fail, wi, ferr;
    logic got_v, got_m, got_r, got_i;
    logic [6:0] ca;
    logic [1:0] mr;
    logic [15:0] r;
    int n_fail = 0, total_checks = 0;
    // Outcome: {fail, restart, int, mode req checked, mode code}
    sfc_case_t cases[18] = '{
        '{sfc_mode_stop, 9'h001, 8'h00, 16'h4081, 6'h30},
        '{sfc_mode_init, 9'h001, 8'h00, 16'h8081, 6'h24},
        '{sfc_mode_init, 9'h001, 8'h00, 16'h4081, 6'h24},
        '{sfc_mode_normal, 9'h001, 8'h00, 16'h0183, 6'h20},
        '{sfc_mode_normal, 9'h001, 8'h00, 16'h0383, 6'h00},
        '{sfc_mode_stop, 9'h001, 8'h00, 16'h238C, 6'h20},
        '{sfc_mode_stop, 9'h001, 8'h00, 16'h0383, 6'h00},
        '{sfc_mode_stop, 9'h001, 8'h00, 16'h0181, 6'h24},
        '{sfc_mode_normal, 9'h000, 8'h00, 16'h4081, 6'h30},
        '{sfc_mode_normal, 9'h000, 8'h00, 16'h8081, 6'h06},
        '{sfc_mode_normal, 9'h101, 8'h00, 16'h4081, 6'h30},
        '{sfc_mode_normal, 9'h001, 8'h01, 16'h8081, 6'h0E},
        '{sfc_mode_normal, 9'h001, 8'h00, 16'h338C, 6'h20},
        '{sfc_mode_normal, 9'h001, 8'h00, 16'h238C, 6'h00},
        '{sfc_mode_normal, 9'h001, 8'h00, 16'h55A0, 6'h00},
        '{sfc_mode_restart, 9'h001, 8'h00, 16'h0000, 6'h00},
        '{sfc_mode_normal, 9'h001, 8'h00, 16'h0000, 6'h20},
        '{sfc_mode_normal, 9'h001, 8'h00, 16'hFFFF, 6'h20}
    };

    // System clock, 40 ns
    initial forever #20 clk = ~clk;

    sfc_spi_frame_check uut (
        .clock_in(clk), .rstn_in(rstn), .chip_select_n_in(cs_n),
        .serial_clock_in(sck), .serial_in_in(serial_in), .reset_output_pin_in(ro),
        .mode_in(mode), .mode_ctrl_shadow_in(shd),
        .wake_source_enable_control_in(wen), .bus_ctrl_enable_in(ben),
        .wake_input_measure_enable_in(meas), .wake_status_first_in(ws),
        .wake_status_second_in(ws), .timer_off_in(toff), .rsp_word_in(rsp_val),
        .serial_out_out(serial_out), .serial_out_oe_out(oe), .cmd_valid_out(cv),
        .cmd_write_out(cw), .cmd_addr_out(ca), .cmd_data_out(cd),
        .mode_req_valid_out(mrv), .mode_req_out(mr), .restart_req_out(rr),
        .cmd_fail_out(fail), .wake_int_out(wi), .frame_err_out(ferr)
    );
    sfc_host_model host (
        .clock_in(clk), .sdo_in(serial_out), .oe_in(oe),
        .cs_n_out(cs_n), .sck_out(sck), .sdi_out(serial_in)
    );

    // One-cycle pulses are latched for later checks
    always @(posedge clk) begin
        if (cv) got_v <= 1'b1;
        if (mrv) got_m <= 1'b1;
        if (rr) got_r <= 1'b1;
        if (wi) got_i <= 1'b1;
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [15:0] w, input int n, input bit hi);
        {got_v, got_m, got_r, got_i} = 4'h0;
        host.frame(w, n, hi, r);
        chk(oe, 1'b0);
    endtask

    task automatic test_done;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        chk({oe, serial_out}, 2'b01);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        xfer(16'h2A81, 16, 0);
        chk(r, {rsp_val, 1'b0});
        chk({got_v, cw, ca, cd}, {2'b11, 7'h01, 8'h2A});
        xfer(16'h2A01, 16, 0);
        chk({got_v, cw}, 2'b10);
        xfer(16'h0000, 16, 0);
        xfer(16'h0383, 16, 0);
        chk(fail, 1'b1);
        xfer(16'h04C3, 16, 0);
        chk(fail, 1'b0);
        foreach (cases[i]) begin
            mode = cases[i].m;
            {meas, wen} = cases[i].env;
            ws = cases[i].st;
            xfer(cases[i].w, 16, 0);
            chk({fail, got_r, got_i, cases[i].e[2] ? {got_m, mr} : 3'h0}, cases[i].e);
            mode = sfc_mode_normal;
            {meas, wen, ws} = 17'h00000;
            xfer(16'h04C3, 16, 0);
            chk(fail, 1'b0);
        end
        // Bus wake enable alone makes sleep legal
        ben = 8'h01;
        xfer(16'h4081, 16, 0);
        chk({fail, got_r, got_m, mr}, 5'h05);
        ben = 8'h00;
        // Stop exit with unchanged other bits stays clean
        mode = sfc_mode_stop;
        shd = 6'h01;
        xfer(16'h0181, 16, 0);
        chk({fail, got_m, mr}, 4'h4);
        mode = sfc_mode_normal;
        shd = 6'h00;
        // Asleep with only a stopped timer to wake it
        mode = sfc_mode_sleep;
        {wen, toff, got_r} = {8'h04, 2'b10};
        repeat (3) @(negedge clk);
        chk(got_r, 1'b1);
        mode = sfc_mode_normal;
        {wen, toff} = 9'h000;
        xfer(16'h0383, 8, 0);
        chk({got_v, ferr}, 2'b01);
        xfer(16'h0000, 0, 0);
        chk({r[0], ferr}, 2'b10);
        xfer(16'h0383, 16, 1);
        chk({got_v, ferr}, 2'b01);
        xfer(16'h0000, 0, 0);
        chk(r[0], 1'b1);
        ro = 1'b0;
        xfer(16'h0383, 16, 0);
        chk({r, got_v}, {16'hFFFF, 1'b0});
        ro = 1'b1;
        xfer(16'h0000, 0, 0);
        chk(r[0], 1'b1);
        test_done();
    end
endmodule // test_sbc_spi_slave_frame_check
